// ==== design/ptc_defs.vh ====
// Register map, field positions, reset values and mode codes of the PWM timer channel
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH
`define PTC_AW              8
`define PTC_DW              32
`define PTC_A_CTRL          8'h00
`define PTC_A_UPSR          8'h04
`define PTC_A_DNSR          8'h08
`define PTC_A_PR            8'h0C
`define PTC_A_PBR           8'h10
`define PTC_A_PDBR          8'h14
`define PTC_A_CCA           8'h18
`define PTC_A_CCB           8'h1C
`define PTC_A_CSA           8'h20
`define PTC_A_CSB           8'h24
`define PTC_A_ICCR          8'h28
`define PTC_A_DTV           8'h2C
`define PTC_A_CNT           8'h30
`define PTC_A_TMPP          8'h34
`define PTC_CTRL_RUN        0
`define PTC_CTRL_ADT        1
`define PTC_CTRL_MD_LO      16
`define PTC_CTRL_MD_HI      19
`define PTC_CTRL_PCS_LO     24
`define PTC_CTRL_PCS_HI     27
`define PTC_CS_XCH          24
`define PTC_ICCR_AFA        0
`define PTC_ICCR_BFA        1
`define PTC_ICCR_AFB        2
`define PTC_ICCR_BFB        3
`define PTC_MD_INIT         4'h0
`define PTC_MD_TRI_BIT      2
`define PTC_MD_CPWM1        4'hC
`define PTC_MD_CPWM4        4'hF
`define PTC_RST_PR          32'hFFFFFFFF
`define PTC_RST_ZERO        32'h00000000
`define PTC_PCS_MAX         4'hA
`endif

// ==== design/ptc_prescaler.v ====
// Count clock enable divider for the timer channel
`default_nettype none
module ptc_prescaler
(
   input  wire        mclk,
   input  wire        rst,
   input  wire        run,
   input  wire [3:0]  pcs,
   output wire        tick
);
`include "ptc_defs.vh"
   reg  [9:0] div_q;
   reg  [9:0] mask;
   integer    i;

   always @*
   begin
      mask = 10'h000;
      for (i = 0; i < 10; i = i + 1)
      begin
         if (i < pcs)
            mask[i] = 1'b1;
      end
   end

   // Stopped divider restarts, so the first count clock is a full period away
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         div_q <= 10'h000;
      else if (!run)
         div_q <= 10'h000;
      else
         div_q <= div_q + 10'h001;
   end

   // Codes above the maximum divide as the maximum
   assign tick = run & ((div_q & mask) == mask);
endmodule // ptc_prescaler
`default_nettype wire

// ==== design/ptc_capture_gate.v ====
// Capture trigger selection for one compare register
`default_nettype none
module ptc_capture_gate
(
   input  wire        mclk,
   input  wire        rst,
   input  wire [3:0]  src_sel,
   input  wire        xch_en,
   input  wire [3:0]  own_ev,
   input  wire        xch_in,
   output reg         cap
);
   // Incoming factors are gated only by the enable, never by the export bits
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         cap <= 1'b0;
      else
         cap <= (|(src_sel & own_ev)) | (xch_en & xch_in);
   end
endmodule // ptc_capture_gate
`default_nettype wire

// ==== design/ptc_channel.v ====
// 32-bit PWM timer channel with capture, automatic dead time and period double buffer
`default_nettype none
module ptc_channel
(
   input  wire        mclk,
   input  wire        rst,
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_we,
   input  wire        reg_re,
   output reg  [31:0] reg_rdata,
   input  wire        cap_pin_a,
   input  wire        cap_pin_b,
   input  wire        evt_up_pin,
   input  wire        evt_dn_pin,
   input  wire        xch_cap_a_in,
   input  wire        xch_cap_b_in,
   input  wire        slave2_ccd_wr,
   output reg         xch_cap_a_out,
   output reg         xch_cap_b_out,
   output reg         pwm_out_a,
   output reg         pwm_out_b,
   output reg  [31:0] timer_counter,
   output reg         crest_pulse,
   output reg         trough_pulse,
   output reg         cpwm_mode4
);
`include "ptc_defs.vh"

   function is_cpwm;
      input [3:0] md;
      begin
         is_cpwm = (md >= `PTC_MD_CPWM1);
      end
   endfunction

   reg  [31:0] ctrl_q;
   reg  [31:0] upsr_q;
   reg  [31:0] dnsr_q;
   reg  [31:0] pr_q;
   reg  [31:0] pbr_q;
   reg  [31:0] pdbr_q;
   reg  [31:0] tmpp_q;
   reg  [31:0] cca_q;
   reg  [31:0] ccb_q;
   reg  [31:0] csa_q;
   reg  [31:0] csb_q;
   reg  [31:0] iccr_q;
   reg  [31:0] dtv_q;
   reg         dn_dir_q;
   reg         adt_pend_q;
   reg         xfer_pend_q;
   reg  [3:0]  s1_q;
   reg  [3:0]  s2_q;
   reg  [3:0]  s3_q;
   reg  [31:0] rd_d;
   reg  [31:0] cnt_d;
   reg         dir_d;
   reg         crest_d;
   reg         trough_d;
   reg         wrap_d;

   wire        run     = ctrl_q[`PTC_CTRL_RUN];
   wire        adt_en  = ctrl_q[`PTC_CTRL_ADT];
   wire [3:0]  md      = ctrl_q[`PTC_CTRL_MD_HI:`PTC_CTRL_MD_LO];
   wire [3:0]  pcs     = ctrl_q[`PTC_CTRL_PCS_HI:`PTC_CTRL_PCS_LO];
   wire        evt_mode = (|upsr_q) | (|dnsr_q);
   wire        tri_mode = md[`PTC_MD_TRI_BIT] | is_cpwm(md);
   wire        tick;
   wire        cap_a;
   wire        cap_b;
   wire        wr_ctrl = reg_we & (reg_addr == `PTC_A_CTRL);
   wire        wr_pr   = reg_we & (reg_addr == `PTC_A_PR);
   wire        wr_pdbr = reg_we & (reg_addr == `PTC_A_PDBR);
   wire        wr_cca  = reg_we & (reg_addr == `PTC_A_CCA);
   wire        wr_ccb  = reg_we & (reg_addr == `PTC_A_CCB);
   wire        wr_dtv  = reg_we & (reg_addr == `PTC_A_DTV);
   // Own capture events: rising A, falling A, rising B, falling B
   wire [3:0]  own_ev  = {~s2_q[1] & s3_q[1], s2_q[1] & ~s3_q[1],
                          ~s2_q[0] & s3_q[0], s2_q[0] & ~s3_q[0]};
   wire        up_ev   = s2_q[2] & ~s3_q[2];
   wire        dn_ev   = s2_q[3] & ~s3_q[3];
   // Dead time clamped to the period, so compare B never runs past the crest
   wire [32:0] adt_sum = {1'b0, cca_q} + {1'b0, dtv_q};
   wire [31:0] adt_val = (adt_sum > {1'b0, pr_q}) ? pr_q : adt_sum[31:0];

   ptc_prescaler u_pre
   (
      .mclk (mclk),
      .rst  (rst),
      .run  (run),
      .pcs  (pcs),
      .tick (tick)
   );

   ptc_capture_gate u_gate_a
   (
      .mclk    (mclk),
      .rst     (rst),
      .src_sel (csa_q[3:0]),
      .xch_en  (csa_q[`PTC_CS_XCH]),
      .own_ev  (own_ev),
      .xch_in  (xch_cap_a_in),
      .cap     (cap_a)
   );

   ptc_capture_gate u_gate_b
   (
      .mclk    (mclk),
      .rst     (rst),
      .src_sel (csb_q[3:0]),
      .xch_en  (csb_q[`PTC_CS_XCH]),
      .own_ev  (own_ev),
      .xch_in  (xch_cap_b_in),
      .cap     (cap_b)
   );

   // Pins pass two flops before use; the third flop only serves edge detection
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
      end
      else
      begin
         s1_q <= {evt_dn_pin, evt_up_pin, cap_pin_b, cap_pin_a};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always @*
   begin
      cnt_d    = timer_counter;
      dir_d    = dn_dir_q;
      crest_d  = 1'b0;
      trough_d = 1'b0;
      wrap_d   = 1'b0;
      if (run && evt_mode)
      begin
         // Event counting ignores the mode field
         if (up_ev && !dn_ev)
            cnt_d = timer_counter + 32'h00000001;
         else if (dn_ev && !up_ev)
            cnt_d = timer_counter - 32'h00000001;
      end
      else if (run && tick)
      begin
         if (!tri_mode)
         begin
            if (timer_counter >= pr_q)
            begin
               cnt_d  = `PTC_RST_ZERO;
               wrap_d = 1'b1;
            end
            else
               cnt_d = timer_counter + 32'h00000001;
         end
         else if (!dn_dir_q)
         begin
            if (timer_counter >= pr_q)
            begin
               dir_d   = 1'b1;
               crest_d = 1'b1;
               cnt_d   = timer_counter - 32'h00000001;
            end
            else
               cnt_d = timer_counter + 32'h00000001;
         end
         else
         begin
            if (timer_counter == `PTC_RST_ZERO)
            begin
               dir_d    = 1'b0;
               trough_d = 1'b1;
               wrap_d   = 1'b1;
               cnt_d    = 32'h00000001;
            end
            else
               cnt_d = timer_counter - 32'h00000001;
         end
      end
   end

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q        <= `PTC_RST_ZERO;
         upsr_q        <= `PTC_RST_ZERO;
         dnsr_q        <= `PTC_RST_ZERO;
         pr_q          <= `PTC_RST_PR;
         pbr_q         <= `PTC_RST_PR;
         pdbr_q        <= `PTC_RST_PR;
         tmpp_q        <= `PTC_RST_PR;
         cca_q         <= `PTC_RST_PR;
         ccb_q         <= `PTC_RST_PR;
         csa_q         <= `PTC_RST_ZERO;
         csb_q         <= `PTC_RST_ZERO;
         iccr_q        <= `PTC_RST_ZERO;
         dtv_q         <= `PTC_RST_ZERO;
         timer_counter <= `PTC_RST_ZERO;
         dn_dir_q      <= 1'b0;
         adt_pend_q    <= 1'b0;
         xfer_pend_q   <= 1'b0;
         crest_pulse   <= 1'b0;
         trough_pulse  <= 1'b0;
      end
      else
      begin
         timer_counter <= cnt_d;
         dn_dir_q      <= run ? dir_d : 1'b0;
         crest_pulse   <= crest_d;
         trough_pulse  <= trough_d;
         if (wr_ctrl)
         begin
            ctrl_q[`PTC_CTRL_RUN] <= reg_wdata[`PTC_CTRL_RUN];
            ctrl_q[`PTC_CTRL_ADT] <= reg_wdata[`PTC_CTRL_ADT];
            ctrl_q[`PTC_CTRL_PCS_HI:`PTC_CTRL_PCS_LO] <=
               reg_wdata[`PTC_CTRL_PCS_HI:`PTC_CTRL_PCS_LO];
            if (!run)
               ctrl_q[`PTC_CTRL_MD_HI:`PTC_CTRL_MD_LO] <=
                  reg_wdata[`PTC_CTRL_MD_HI:`PTC_CTRL_MD_LO];
         end
         if (reg_we && reg_addr == `PTC_A_UPSR)
            upsr_q <= reg_wdata;
         if (reg_we && reg_addr == `PTC_A_DNSR)
            dnsr_q <= reg_wdata;
         if (reg_we && reg_addr == `PTC_A_CSA)
            csa_q <= reg_wdata;
         if (reg_we && reg_addr == `PTC_A_CSB)
            csb_q <= reg_wdata;
         if (reg_we && reg_addr == `PTC_A_ICCR)
            iccr_q <= reg_wdata;
         if (reg_we && reg_addr == `PTC_A_PBR)
            pbr_q <= reg_wdata;
         if (wr_dtv)
            dtv_q <= reg_wdata;
         if (wr_pdbr)
            pdbr_q <= reg_wdata;
         // Buffer chain steps at the end of each cycle in complementary modes, except when PR is written in that cycle
         if (wr_pr)
            pr_q <= reg_wdata;
         else if (wrap_d && is_cpwm(md))
         begin
            pr_q  <= pbr_q;
            pbr_q <= tmpp_q;
         end
         // Run state is sampled alongside the trigger, not at the transfer
         if (is_cpwm(md))
            xfer_pend_q <= (run & slave2_ccd_wr) | (~run & wr_pdbr);
         else
            xfer_pend_q <= 1'b0;
         if (xfer_pend_q)
            tmpp_q <= pdbr_q;
         if (cap_a)
            cca_q <= timer_counter;
         else if (wr_cca)
            cca_q <= reg_wdata;
         // New triggers win over the load that consumes the pending flag
         adt_pend_q <= (adt_pend_q & ~(run & tick)) | (adt_en & (wr_cca | wr_dtv | wr_pr))
                       | (adt_en & crest_d);
         if (cap_b)
            ccb_q <= timer_counter;
         else if (adt_en && adt_pend_q && run && tick)
            ccb_q <= adt_val;
         else if (wr_ccb && !adt_en)
            ccb_q <= reg_wdata;
      end
   end

   // Exported factors feed the other channels' cross-channel inputs
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         xch_cap_a_out <= 1'b0;
         xch_cap_b_out <= 1'b0;
         pwm_out_a     <= 1'b0;
         pwm_out_b     <= 1'b0;
         cpwm_mode4    <= 1'b0;
      end
      else
      begin
         xch_cap_a_out <= (cap_a & iccr_q[`PTC_ICCR_AFA]) | (cap_b & iccr_q[`PTC_ICCR_BFA]);
         xch_cap_b_out <= (cap_a & iccr_q[`PTC_ICCR_AFB]) | (cap_b & iccr_q[`PTC_ICCR_BFB]);
         pwm_out_a     <= run & (timer_counter < cca_q);
         pwm_out_b     <= run & ~(timer_counter < ccb_q);
         cpwm_mode4    <= (md == `PTC_MD_CPWM4);
      end
   end

   always @*
   begin
      case (reg_addr)
         `PTC_A_CTRL: rd_d = ctrl_q;
         `PTC_A_UPSR: rd_d = upsr_q;
         `PTC_A_DNSR: rd_d = dnsr_q;
         `PTC_A_PR:   rd_d = pr_q;
         `PTC_A_PBR:  rd_d = pbr_q;
         `PTC_A_PDBR: rd_d = pdbr_q;
         `PTC_A_CCA:  rd_d = cca_q;
         `PTC_A_CCB:  rd_d = ccb_q;
         `PTC_A_CSA:  rd_d = csa_q;
         `PTC_A_CSB:  rd_d = csb_q;
         `PTC_A_ICCR: rd_d = iccr_q;
         `PTC_A_DTV:  rd_d = dtv_q;
         `PTC_A_CNT:  rd_d = timer_counter;
         `PTC_A_TMPP: rd_d = tmpp_q;
         default:     rd_d = `PTC_RST_ZERO;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         reg_rdata <= `PTC_RST_ZERO;
      else if (reg_re)
         reg_rdata <= rd_d;
      else
         reg_rdata <= `PTC_RST_ZERO;
   end
endmodule // ptc_channel
`default_nettype wire

// ==== tb/ptc_channel_asserts.sv ====
// Port-level property checker for the PWM timer channel
`default_nettype none
`include "ptc_defs.vh"
module ptc_channel_asserts
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_we,
   input wire logic        xch_cap_a_in,
   input wire logic        xch_cap_b_in,
   input wire logic        xch_cap_a_out,
   input wire logic        xch_cap_b_out,
   input wire logic        crest_pulse,
   input wire logic        cpwm_mode4
);
   logic       run_q;
   logic [3:0] md_q;
   logic [3:0] csa_q;
   logic [3:0] csb_q;
   logic [3:0] iccr_q;
   logic       xa_en_q;
   logic       xb_en_q;
   wire        ctl_wr;
   wire        quiet;
   assign ctl_wr = reg_we && reg_addr == `PTC_A_CTRL;
   assign quiet  = csa_q == 4'h0 && csb_q == 4'h0;
   // Shadow of the control state; mode only follows writes made while stopped
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         run_q  <= 1'b0;
         md_q   <= 4'h0;
         csa_q  <= 4'h0;
         csb_q  <= 4'h0;
         iccr_q <= 4'h0;
         xa_en_q <= 1'b0;
         xb_en_q <= 1'b0;
      end
      else
      begin
         if (ctl_wr)
            run_q <= reg_wdata[0];
         if (ctl_wr && !run_q)
            md_q <= reg_wdata[19:16];
         if (reg_we && reg_addr == `PTC_A_CSA)
         begin
            csa_q   <= reg_wdata[3:0];
            xa_en_q <= reg_wdata[`PTC_CS_XCH];
         end
         if (reg_we && reg_addr == `PTC_A_CSB)
         begin
            csb_q   <= reg_wdata[3:0];
            xb_en_q <= reg_wdata[`PTC_CS_XCH];
         end
         if (reg_we && reg_addr == `PTC_A_ICCR)
            iccr_q <= reg_wdata[3:0];
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   property p_mode4_on;
      ctl_wr && !run_q && reg_wdata[19:16] == `PTC_MD_CPWM4 |-> ##[1:2] cpwm_mode4;
   endproperty
   a_mode4_on: assert property (p_mode4_on) else $error("mode 4 flag not raised");
   property p_mode4_off;
      ctl_wr && !run_q && reg_wdata[19:16] != `PTC_MD_CPWM4 |-> ##2 !cpwm_mode4;
   endproperty
   a_mode4_off: assert property (p_mode4_off) else $error("mode 4 flag wrongly set");
   property p_mode_locked;
      ctl_wr && run_q && md_q == $past(md_q, 2) |=> $stable(cpwm_mode4) [*2];
   endproperty
   a_mode_locked: assert property (p_mode_locked) else $error("mode changed while running");
   // Incoming factors are captured, and so re-exported, only with the enable set
   property p_xa_noexp;
      xch_cap_a_in && !xch_cap_b_in && !xa_en_q && quiet
         |-> ##2 !xch_cap_a_out && !xch_cap_b_out;
   endproperty
   a_xa_noexp: assert property (p_xa_noexp) else $error("A capture while disabled");
   property p_xb_noexp;
      xch_cap_b_in && !xch_cap_a_in && !xb_en_q && quiet
         |-> ##2 !xch_cap_a_out && !xch_cap_b_out;
   endproperty
   a_xb_noexp: assert property (p_xb_noexp) else $error("B capture while disabled");
   property p_xa_cap;
      xch_cap_a_in && xa_en_q && iccr_q[`PTC_ICCR_AFA] |-> ##2 xch_cap_a_out;
   endproperty
   a_xa_cap: assert property (p_xa_cap) else $error("enabled A factor not captured");
   property p_xb_cap;
      xch_cap_b_in && xb_en_q && iccr_q[`PTC_ICCR_BFB] |-> ##2 xch_cap_b_out;
   endproperty
   a_xb_cap: assert property (p_xb_cap) else $error("enabled B factor not captured");
   property p_exp_a;
      xch_cap_a_out |-> iccr_q[`PTC_ICCR_AFA] || iccr_q[`PTC_ICCR_BFA];
   endproperty
   a_exp_a: assert property (p_exp_a) else $error("export A without config");
   property p_exp_b;
      xch_cap_b_out |-> iccr_q[`PTC_ICCR_AFB] || iccr_q[`PTC_ICCR_BFB];
   endproperty
   a_exp_b: assert property (p_exp_b) else $error("export B without config");
   // Pulse lags the turn by a cycle, so a stop at that edge must not count
   property p_crest;
      crest_pulse |-> $past(md_q[`PTC_MD_TRI_BIT] && run_q);
   endproperty
   a_crest: assert property (p_crest) else $error("crest outside triangle count");
endmodule // ptc_channel_asserts
bind ptc_channel ptc_channel_asserts u_chk
(
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
   .xch_cap_a_in(xch_cap_a_in), .xch_cap_b_in(xch_cap_b_in), .xch_cap_a_out(xch_cap_a_out),
   .xch_cap_b_out(xch_cap_b_out), .crest_pulse(crest_pulse), .cpwm_mode4(cpwm_mode4)
);
`default_nettype wire

// ==== tb/ptc_channel_test.sv ====
// Self-checking bench for the PWM timer channel
`default_nettype none
`include "ptc_defs.vh"
module ptc_channel_test;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} ptc_row_t;
   logic        mclk, rst, reg_we, reg_re, cap_pin_a, cap_pin_b, evt_up_pin, evt_dn_pin;
   logic        xch_cap_a_in, xch_cap_b_in, slave2_ccd_wr, xch_cap_a_out, xch_cap_b_out;
   logic        pwm_out_a, pwm_out_b, crest_pulse, trough_pulse, cpwm_mode4;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, timer_counter, got;
   int          err_total, n_compared, cyc, i, k;
   // Write to 0xFC is unmapped, so those rows only read reset values
   ptc_row_t rows [8] = '{
      '{8'hFC, 32'h0, `PTC_A_PR, 32'hFFFFFFFF}, '{8'hFC, 32'h0, `PTC_A_CTRL, 32'h0},
      '{`PTC_A_CSA, 32'h01000000, `PTC_A_CSA, 32'h01000000},
      '{`PTC_A_CSB, 32'h01000000, `PTC_A_CSB, 32'h01000000},
      '{`PTC_A_ICCR, 32'hF, `PTC_A_ICCR, 32'hF}, '{`PTC_A_TMPP, 32'h0, `PTC_A_TMPP, 32'hFFFFFFFF},
      '{8'h3C, 32'h12345678, 8'h3C, 32'h0}, '{`PTC_A_CCA, 32'h55, `PTC_A_CCA, 32'h55}};
   ptc_channel DUT
   (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata), .cap_pin_a(cap_pin_a), .cap_pin_b(cap_pin_b),
      .evt_up_pin(evt_up_pin), .evt_dn_pin(evt_dn_pin), .xch_cap_a_in(xch_cap_a_in),
      .xch_cap_b_in(xch_cap_b_in), .slave2_ccd_wr(slave2_ccd_wr), .xch_cap_a_out(xch_cap_a_out),
      .xch_cap_b_out(xch_cap_b_out), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
      .timer_counter(timer_counter), .crest_pulse(crest_pulse), .trough_pulse(trough_pulse),
      .cpwm_mode4(cpwm_mode4)
   );
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         wrap_up();
      end
   end
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_we    <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_re   <= 1'b0;
      @(negedge mclk);
      got = reg_rdata;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] act);
      n_compared++;
      if (act !== exp)
      begin
         err_total++;
         $display("Error at %0t ns: expected %h got %h", $time, exp, act);
      end
   endtask
   task automatic chkrd(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(exp, got);
   endtask
   // 0: factor into A, 1: factor into B, else slave compare D write
   task automatic pulse(input int which);
      @(posedge mclk);
      xch_cap_a_in  <= which == 0;
      xch_cap_b_in  <= which == 1;
      slave2_ccd_wr <= which > 1;
      @(posedge mclk);
      xch_cap_a_in  <= 1'b0;
      xch_cap_b_in  <= 1'b0;
      slave2_ccd_wr <= 1'b0;
      idle(3);
   endtask
   initial
   begin
      {reg_we, reg_re, cap_pin_a, cap_pin_b, evt_up_pin, evt_dn_pin} = 6'h00;
      {xch_cap_a_in, xch_cap_b_in, slave2_ccd_wr} = 3'h0;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      rst       = 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 8; i++)
      begin
         wr(rows[i].wa, rows[i].wd);
         idle(2);
         chkrd(rows[i].ra, rows[i].ex);
      end
      // Counter never ran, so a capture loads 0
      for (k = 0; k < 2; k++)
      begin
         wr(`PTC_A_CSA + 8'(4 * k), 32'h0);
         pulse(k);
         chkrd(`PTC_A_CCA + 8'(4 * k), k ? 32'hFFFFFFFF : 32'h55);
         wr(`PTC_A_CSA + 8'(4 * k), 32'h01000000);
         pulse(k);
         chkrd(`PTC_A_CCA + 8'(4 * k), 32'h0);
      end
      wr(`PTC_A_CSA, 32'h01000001);
      cap_pin_a <= 1'b1;
      for (i = 0; i < 20 && xch_cap_a_out !== 1'b1; i++)
         @(negedge mclk);
      chk(32'h1, {31'h0, xch_cap_a_out});
      @(posedge mclk);
      cap_pin_a <= 1'b0;
      wr(`PTC_A_PR, 32'h100);
      wr(`PTC_A_CCA, 32'h20);
      wr(`PTC_A_CTRL, 32'h3);
      wr(`PTC_A_DTV, 32'h10);
      idle(3);
      chkrd(`PTC_A_CCB, 32'h30);
      // Compare B is never written and dead time stays inside the period
      wr(`PTC_A_CCA, 32'h40);
      idle(3);
      chkrd(`PTC_A_CCB, 32'h50);
      wr(`PTC_A_DTV, 32'h20);
      idle(3);
      chkrd(`PTC_A_CCB, 32'h60);
      wr(`PTC_A_CTRL, 32'h0);
      wr(`PTC_A_CTRL, 32'h000C0000);
      // Prescale 0: count clock on every cycle
      wr(`PTC_A_CTRL, 32'h000C0000);
      wr(`PTC_A_PR, 32'h100);
      wr(`PTC_A_PBR, 32'h100);
      wr(`PTC_A_PDBR, 32'h3000);
      idle(2);
      chkrd(`PTC_A_TMPP, 32'h3000);
      wr(`PTC_A_CTRL, 32'h000C0001);
      wr(`PTC_A_PDBR, 32'h5000);
      idle(2);
      chkrd(`PTC_A_TMPP, 32'h3000);
      pulse(2);
      chkrd(`PTC_A_TMPP, 32'h5000);
      wr(`PTC_A_CTRL, 32'h000F0001);
      idle(2);
      chk(32'h0, {31'h0, cpwm_mode4});
      // Long enough to pass the crest of a 0x100 triangle
      idle(300);
      wr(`PTC_A_CTRL, 32'h0);
      wr(`PTC_A_CTRL, 32'h000F0000);
      idle(2);
      chk(32'h1, {31'h0, cpwm_mode4});
      @(posedge mclk);
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      chkrd(`PTC_A_CTRL, 32'h0);
      chk(32'h0, {31'h0, cpwm_mode4});
      // Event counting with the mode field left at 0000b
      wr(`PTC_A_UPSR, 32'h1);
      wr(`PTC_A_DNSR, 32'h1);
      wr(`PTC_A_CTRL, 32'h1);
      evt_up_pin <= 1'b1;
      idle(6);
      chkrd(`PTC_A_CNT, 32'h1);
      chk(32'h1, timer_counter);
      chk(32'h1, {31'h0, pwm_out_a});
      chk(32'h0, {31'h0, pwm_out_b});
      evt_dn_pin <= 1'b1;
      idle(6);
      chkrd(`PTC_A_CNT, 32'h0);
      wrap_up();
   end
endmodule // ptc_channel_test
`default_nettype wire
